// *** core/xmove_pkg.sv ***
// constants shared by the memory-transfer and computed-branch executor
package xmove_pkg;
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int IRAM_BYTES  = 256;
  localparam int IRAM_AW     = 8;
  // opcode encodings of the handled instructions
  localparam logic [7:0] OP_XRD_DP   = 8'he0;
  localparam logic [7:0] OP_XRD_R0   = 8'he2;
  localparam logic [7:0] OP_XRD_R1   = 8'he3;
  localparam logic [7:0] OP_XWR_DP   = 8'hf0;
  localparam logic [7:0] OP_XWR_R0   = 8'hf2;
  localparam logic [7:0] OP_XWR_R1   = 8'hf3;
  localparam logic [7:0] OP_CT_DP    = 8'h93;
  localparam logic [7:0] OP_CT_PC    = 8'h83;
  localparam logic [7:0] OP_JMP_IND  = 8'h73;
  localparam logic [7:0] OP_COMPARE_BRANCH_UNEQUAL_IMM = 8'hb4;
  localparam logic [7:0] OP_LONG_JUMP     = 8'h02;
  localparam logic [7:0] OP_RET      = 8'h22;
  localparam logic [4:0] ABSOLUTE_SHORT_JUMP_LOW    = 5'h01;
  // instruction lengths in bytes
  localparam logic [1:0] LEN_ONE     = 2'h1;
  localparam logic [1:0] LEN_TWO     = 2'h2;
  localparam logic [1:0] LEN_THREE   = 2'h3;
  localparam logic [15:0] RESET_DP   = 16'h0000;
  localparam logic [7:0]  RESET_ACC  = 8'h00;
  localparam logic [15:0] RESET_PC   = 16'h0000;
  // idle levels of the bus outputs after reset
  localparam logic [15:0] RESET_ADDR = 16'h0000;
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  // internal ram bytes that double as pointer registers zero and one
  localparam logic [7:0]  PTR0_ADDR  = 8'h00;
  localparam logic [7:0]  PTR1_ADDR  = 8'h01;
  // upper address byte of every pointer register access
  localparam logic [7:0]  PTR_PAGE   = 8'h00;
endpackage

// *** core/xmove_exec.sv ***
// executor for external data moves, code table reads and indirect jump
`timescale 1ns/10ps
// Operation
// - internal data ram of 128 or 256 bytes, separate from external space
// - external data space up to 64k bytes, reached only by external moves
// - data pointer form drives all 16 pointer bits as address
// - external read via data pointer loads the fetched byte to accumulator
// - external read via pointer register zero or one loads accumulator
// - external write via data pointer stores accumulator at pointer address
// - external write via pointer register stores accumulator at its address
// - pointer register accesses reach only addresses 0000h to 00ffh
// - code table read at accumulator plus data pointer into accumulator
// - code table read at accumulator plus next instruction address
// - indirect jump loads program counter with accumulator plus pointer
// - compare branch unequal is 3 bytes, absolute short jump 2 bytes
// - long jump is 3 bytes, subroutine return is 1 byte
// - data pointer is two separately writable bytes used as one address
module xmove_exec #(
  parameter int IRAM_SIZE = xmove_pkg::IRAM_BYTES
) (
  input  wire logic        clock_in,       // core clock
  input  wire logic        nrst_in,        // sync reset, active low
  input  wire logic        issue_in,       // opcode valid pulse
  input  wire logic [7:0]  opcode_in,      // instruction opcode
  input  wire logic        dph_we_in,      // write high pointer byte
  input  wire logic        dpl_we_in,      // write low pointer byte
  input  wire logic        acc_we_in,      // write accumulator
  input  wire logic        ir_we_in,       // write internal ram byte
  input  wire logic [7:0]  ir_addr_in,     // internal ram address
  input  wire logic [7:0]  wdata_in,       // byte for the writes above
  input  wire logic [7:0]  xram_rdata_in,  // external read data
  input  wire logic [7:0]  code_rdata_in,  // code memory read data
  output logic [15:0]      xram_addr_out,  // external address
  output logic [7:0]       xram_wdata_out, // external write data
  output logic             xram_rd_out,    // external read strobe
  output logic             xram_wr_out,    // external write strobe
  output logic [15:0]      code_addr_out,  // code table address
  output logic             code_rd_out,    // code read strobe
  output logic [15:0]      pc_out,         // program counter
  output logic [7:0]       acc_out,        // accumulator
  output logic [15:0]      data_pointer_out,       // data pointer
  output logic [7:0]       ir_rdata_out,   // internal ram read data
  output logic [1:0]       length_out,     // decoded length in bytes
  output logic             busy_out        // read transfer in progress
);
  // each wait state is one bit away from idle; code 2'b11 is illegal
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XRD  = 2'b01,
    ST_CRD  = 2'b10
  } state_e;

  // the ram index below only serves these two sizes
  if (IRAM_SIZE != 128 && IRAM_SIZE != 256) begin : g_bad_iram_size
    $error("internal ram must be 128 or 256 bytes");
  end

  state_e      state_q;
  logic [7:0]  dph_q;
  logic [7:0]  dpl_q;
  logic [7:0]  acc_q;
  logic [15:0] pc_q;
  logic [7:0]  iram_q [IRAM_SIZE];
  logic [15:0] data_pointer;
  logic [15:0] pc_next;
  logic [1:0]  len;
  logic [7:0]  rsel;
  logic        rd_start;

  // the two halves act as one address whenever memory is reached
  assign data_pointer = {dph_q, dpl_q};
  // pointer registers live at internal ram bytes 0 and 1; opcode bit
  // zero picks register one, in both read and write encodings
  assign rsel = opcode_in[0] ? iram_q[xmove_pkg::PTR1_ADDR]
                             : iram_q[xmove_pkg::PTR0_ADDR];

  // a read that will own the next cycle; busy mirrors exactly that
  // cycle, so a caller gating issue on busy is never refused
  assign rd_start = issue_in && (state_q == ST_IDLE) &&
    (opcode_in inside {xmove_pkg::OP_XRD_DP, xmove_pkg::OP_XRD_R0,
                       xmove_pkg::OP_XRD_R1, xmove_pkg::OP_CT_DP,
                       xmove_pkg::OP_CT_PC});

  // length decode; absolute short jump uses low five opcode bits
  // opcodes not listed step one byte; the core around us owns them
  always_comb begin
    len = xmove_pkg::LEN_ONE;
    if (opcode_in == xmove_pkg::OP_COMPARE_BRANCH_UNEQUAL_IMM)
      len = xmove_pkg::LEN_THREE;
    else if (opcode_in[4:0] == xmove_pkg::ABSOLUTE_SHORT_JUMP_LOW)
      len = xmove_pkg::LEN_TWO;
    else if (opcode_in == xmove_pkg::OP_LONG_JUMP)
      len = xmove_pkg::LEN_THREE;
    else if (opcode_in == xmove_pkg::OP_RET)
      len = xmove_pkg::LEN_ONE;
  end
  // address of the next instruction, also the pc table read base
  assign pc_next = 16'(pc_q + {14'h0000, len});

  // internal ram, separate from external space; ports only
  // no reset: the contents are undefined at power-up anyway
  always_ff @(posedge clock_in) begin
    if (ir_we_in)
      iram_q[ir_addr_in[$clog2(IRAM_SIZE)-1:0]] <= wdata_in;
    ir_rdata_out <= iram_q[ir_addr_in[$clog2(IRAM_SIZE)-1:0]];
  end

  // data pointer halves; each byte written alone
  // writing one half leaves the other byte as it stood
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      dph_q <= xmove_pkg::RESET_DP[15:8];
      dpl_q <= xmove_pkg::RESET_DP[7:0];
    end else begin
      if (dph_we_in)
        dph_q <= wdata_in;
      if (dpl_we_in)
        dpl_q <= wdata_in;
    end
  end

  // sequencer: read data returns in the strobe cycle, taken on the edge ending it
  // strobes pulse for one cycle; addresses stand until the next access
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_q        <= ST_IDLE;
      acc_q          <= xmove_pkg::RESET_ACC;
      pc_q           <= xmove_pkg::RESET_PC;
      xram_addr_out  <= xmove_pkg::RESET_ADDR;
      xram_wdata_out <= xmove_pkg::RESET_BYTE;
      xram_rd_out    <= 1'b0;
      xram_wr_out    <= 1'b0;
      code_addr_out  <= xmove_pkg::RESET_ADDR;
      code_rd_out    <= 1'b0;
      length_out     <= xmove_pkg::LEN_ONE;
    end else begin
      xram_rd_out <= 1'b0;
      xram_wr_out <= 1'b0;
      code_rd_out <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          // accumulator loads are taken only while no read is returning
          if (acc_we_in)
            acc_q <= wdata_in;
          if (issue_in) begin
            length_out <= len;
            pc_q       <= pc_next;
            unique case (opcode_in)
              // full pointer read; the byte is taken on the next edge
              xmove_pkg::OP_XRD_DP: begin
                xram_addr_out <= data_pointer;
                xram_rd_out   <= 1'b1;
                state_q       <= ST_XRD;
              end
              // pointer register read stays in page zero
              xmove_pkg::OP_XRD_R0, xmove_pkg::OP_XRD_R1: begin
                xram_addr_out <= {xmove_pkg::PTR_PAGE, rsel};
                xram_rd_out   <= 1'b1;
                state_q       <= ST_XRD;
              end
              // full pointer write; the partner stores it on the next edge
              xmove_pkg::OP_XWR_DP: begin
                xram_addr_out  <= data_pointer;
                xram_wdata_out <= acc_q;
                xram_wr_out    <= 1'b1;
              end
              // pointer register write, page zero as for reads
              xmove_pkg::OP_XWR_R0, xmove_pkg::OP_XWR_R1: begin
                xram_addr_out  <= {xmove_pkg::PTR_PAGE, rsel};
                xram_wdata_out <= acc_q;
                xram_wr_out    <= 1'b1;
              end
              // absolute table read; the sum wraps in the 64k space
              xmove_pkg::OP_CT_DP: begin
                code_addr_out <= 16'(data_pointer + {8'h00, acc_q});
                code_rd_out   <= 1'b1;
                state_q       <= ST_CRD;
              end
              xmove_pkg::OP_CT_PC: begin
                // address of the following instruction plus accumulator
                code_addr_out <= 16'(pc_next + {8'h00, acc_q});
                code_rd_out   <= 1'b1;
                state_q       <= ST_CRD;
              end
              // jump target replaces the length step taken above
              xmove_pkg::OP_JMP_IND:
                pc_q <= 16'(data_pointer + {8'h00, acc_q});
              default: ;
            endcase
          end
        end
        // the read owns this cycle; an issue here is dropped
        ST_XRD: begin
          acc_q   <= xram_rdata_in;
          state_q <= ST_IDLE;
        end
        // the table byte lands like an external read byte
        ST_CRD: begin
          acc_q   <= code_rdata_in;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // register-fed views of internal state
  // each view lags its source by one cycle so every output is a flop
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pc_out   <= xmove_pkg::RESET_PC;
      acc_out  <= xmove_pkg::RESET_ACC;
      data_pointer_out <= xmove_pkg::RESET_DP;
      busy_out <= 1'b0;
    end else begin
      pc_out   <= pc_q;
      acc_out  <= acc_q;
      data_pointer_out <= data_pointer;
      busy_out <= rd_start; // high exactly while a read returns
    end
  end
endmodule

// *** dv/xmove_exec_properties.sv ***
// port-level assertions for the external move executor
`timescale 1ns/10ps
module xmove_exec_properties (
  input wire logic        clock_in,      // clock
  input wire logic        nrst_in,       // sync reset
  input wire logic        issue_in,      // opcode valid
  input wire logic [7:0]  opcode_in,     // opcode
  input wire logic [7:0]  xram_rdata_in, // read byte
  input wire logic [15:0] xram_addr_out, // ext address
  input wire logic        xram_rd_out,   // read strobe
  input wire logic        xram_wr_out,   // write strobe
  input wire logic        code_rd_out,   // code read strobe
  input wire logic [7:0]  acc_out,       // accumulator
  input wire logic [1:0]  length_out,    // length
  input wire logic        busy_out       // busy
);
  logic take;
  // an opcode counts only while no read is pending
  assign take = issue_in && !busy_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_long_jump_len: assert property (
    take && opcode_in == 8'h02 |=> length_out == 2'h3)
    else $error("long jump length wrong");
  a_ret_len: assert property (
    take && opcode_in == 8'h22 |=> length_out == 2'h1)
    else $error("return length wrong");
  a_compare_branch_unequal_len: assert property (
    take && opcode_in == 8'hb4 |=> length_out == 2'h3)
    else $error("compare branch length wrong");
  a_absolute_short_jump_len: assert property (
    take && opcode_in[4:0] == 5'h01 |=> length_out == 2'h2)
    else $error("short jump length wrong");
  a_write_strobe: assert property (
    take && opcode_in inside {8'hf0, 8'hf2, 8'hf3}
    |=> xram_wr_out && !xram_rd_out) else $error("write strobe missing");
  a_ptr_high_zero: assert property (
    take && opcode_in inside {8'he2, 8'he3, 8'hf2, 8'hf3}
    |=> xram_addr_out[15:8] == 8'h00) else $error("pointer high byte set");
  a_rd_one_cycle: assert property (
    xram_rd_out |=> !xram_rd_out) else $error("read strobe too long");
  a_rd_acc_load: assert property (
    xram_rd_out |-> ##2 acc_out == $past(xram_rdata_in, 2))
    else $error("read byte not in accumulator");
  a_busy_on_read: assert property (
    take && opcode_in inside {8'he0, 8'he2, 8'he3, 8'h93, 8'h83}
    |=> busy_out ##1 !busy_out) else $error("busy not one wait state");
  a_code_strobe: assert property (
    take && opcode_in inside {8'h93, 8'h83}
    |=> code_rd_out && !xram_rd_out && !xram_wr_out)
    else $error("table read touched external bus");
endmodule
bind xmove_exec xmove_exec_properties i_props (.clock_in, .nrst_in,
  .issue_in, .opcode_in, .xram_rdata_in, .xram_addr_out, .xram_rd_out,
  .xram_wr_out, .code_rd_out, .acc_out, .length_out, .busy_out);

// *** dv/xram_model.sv ***
// external data ram model facing the executor
`timescale 1ns/10ps
module xram_model (
  input  wire logic        clock_in,  // clock
  input  wire logic [15:0] addr_in,   // address
  input  wire logic [7:0]  wdata_in,  // write byte
  input  wire logic        rd_in,     // read strobe
  input  wire logic        wr_in,     // write strobe
  output logic [7:0]       rdata_out  // read byte
);
  logic [7:0] mem [65536];
  logic [7:0] last_q = 8'h00;
  // preset so unwritten bytes still read a known pattern
  initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8];
  // one bus cycle per strobe
  always @(posedge clock_in) begin
    if (wr_in) mem[addr_in] <= wdata_in;
    if (rd_in) last_q <= mem[addr_in];
  end
  // released bus shows the inverse, never a stale byte
  assign rdata_out = rd_in ? mem[addr_in] : ~last_q;
endmodule

// *** dv/tb.sv ***
// self-checking bench for the external move executor
`timescale 1ns/10ps
module tb;
  logic        clock_in, nrst_in, issue_in, dph_we_in, dpl_we_in;
  logic        acc_we_in, ir_we_in, xram_rd_out, xram_wr_out;
  logic        code_rd_out, busy_out;
  logic [7:0]  opcode_in, ir_addr_in, wdata_in, xram_rdata_in;
  logic [7:0]  code_rdata_in, xram_wdata_out, acc_out, ir_rdata_out;
  logic [15:0] xram_addr_out, code_addr_out, pc_out, data_pointer_out, p;
  logic [1:0]  length_out;
  int          err_count, tests_run;
  xmove_exec i_dut (.clock_in, .nrst_in, .issue_in, .opcode_in,
    .dph_we_in, .dpl_we_in, .acc_we_in, .ir_we_in, .ir_addr_in,
    .wdata_in, .xram_rdata_in, .code_rdata_in, .xram_addr_out,
    .xram_wdata_out, .xram_rd_out, .xram_wr_out, .code_addr_out,
    .code_rd_out, .pc_out, .acc_out, .data_pointer_out, .ir_rdata_out,
    .length_out, .busy_out);
  xram_model i_xram (.clock_in(clock_in), .addr_in(xram_addr_out),
    .wdata_in(xram_wdata_out), .rd_in(xram_rd_out),
    .wr_in(xram_wr_out), .rdata_out(xram_rdata_in));
  // code byte is a fold of its address; inverted low address byte when not read
  assign code_rdata_in = code_rd_out ?
    code_addr_out[7:0] ^ code_addr_out[15:8] : ~code_addr_out[7:0];
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // m selects dph, dpl, acc, internal ram
  task automatic setr(logic [3:0] m, logic [7:0] a, logic [7:0] v);
    @(negedge clock_in);
    {dph_we_in, dpl_we_in, acc_we_in, ir_we_in} = m;
    ir_addr_in = a;
    wdata_in = v;
    @(negedge clock_in);
    {dph_we_in, dpl_we_in, acc_we_in, ir_we_in} = 4'h0;
  endtask
  task automatic iss(logic [7:0] o);
    @(negedge clock_in);
    issue_in = 1'b1;
    opcode_in = o;
    @(negedge clock_in);
    issue_in = 1'b0;
  endtask
  task automatic t_xdp();
    setr(4'h8, 8'h00, 8'h23);
    setr(4'h4, 8'h00, 8'h56);
    setr(4'h2, 8'h00, 8'h5a);
    iss(8'hf0);
    chk("xwr", 16'h1, xram_wr_out);
    chk("xaddr", 16'h2356, xram_addr_out);
    chk("xwdata", 16'h5a, xram_wdata_out);
    setr(4'h2, 8'h00, 8'h00);
    chk("xwr_end", 16'h0, xram_wr_out);
    iss(8'he0);
    chk("xrd", 16'h1, xram_rd_out);
    chk("busy", 16'h1, busy_out);
    repeat (2) @(negedge clock_in);
    chk("acc", 16'h5a, acc_out);
    chk("busy_end", 16'h0, busy_out);
    chk("data_pointer", 16'h2356, data_pointer_out);
  endtask
  task automatic t_xptr();
    setr(4'h1, 8'h00, 8'h80);
    setr(4'h1, 8'h01, 8'hff);
    setr(4'h2, 8'h00, 8'hc3);
    iss(8'hf2);
    chk("r0addr", 16'h0080, xram_addr_out);
    iss(8'hf3);
    chk("r1addr", 16'h00ff, xram_addr_out);
    setr(4'h2, 8'h00, 8'h00);
    iss(8'he2);
    repeat (2) @(negedge clock_in);
    chk("acc_r0", 16'hc3, acc_out);
    setr(4'h2, 8'h00, 8'h00);
    iss(8'he3);
    chk("r1rdaddr", 16'h00ff, xram_addr_out);
    repeat (2) @(negedge clock_in);
    chk("acc_r1", 16'hc3, acc_out);
  endtask
  task automatic t_code();
    setr(4'h8, 8'h00, 8'hff);
    setr(4'h4, 8'h00, 8'hf0);
    setr(4'h2, 8'h00, 8'h20);
    iss(8'h93);
    chk("caddr", 16'h0010, code_addr_out);
    chk("crd", 16'h1, code_rd_out);
    chk("ct_xrd", 16'h0, xram_rd_out);
    repeat (2) @(negedge clock_in);
    chk("acc_ct", 16'h10, acc_out);
    p = pc_out + 16'h11;
    iss(8'h83);
    chk("caddr_pc", p, code_addr_out);
    chk("crd_pc", 16'h1, code_rd_out);
    repeat (2) @(negedge clock_in);
    chk("acc_pc", {8'h00, p[7:0] ^ p[15:8]}, acc_out);
  endtask
  task automatic t_jmp();
    setr(4'h8, 8'h00, 8'h20);
    @(negedge clock_in);
    chk("dph_only", 16'h20f0, data_pointer_out);
    setr(4'h4, 8'h00, 8'h00);
    setr(4'h2, 8'h00, 8'h14);
    iss(8'h73);
    chk("jmp_xwr", 16'h0, xram_wr_out);
    @(negedge clock_in);
    chk("pc_jmp", 16'h2014, pc_out);
  endtask
  task automatic t_len();
    logic [7:0] ops [4] = '{8'hb4, 8'h02, 8'h22, 8'he1};
    logic [1:0] lens [4] = '{2'h3, 2'h3, 2'h1, 2'h2};
    for (int i = 0; i < 4; i++) begin
      p = pc_out + lens[i];
      iss(ops[i]);
      chk("len", lens[i], length_out);
      @(negedge clock_in);
      chk("pc_step", p, pc_out);
    end
  endtask
  task automatic t_iram();
    setr(4'h1, 8'h7f, 8'ha5);
    @(negedge clock_in);
    chk("iram", 16'ha5, ir_rdata_out);
  endtask
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    {nrst_in, issue_in, opcode_in, dph_we_in, dpl_we_in} = '0;
    {acc_we_in, ir_we_in, ir_addr_in, wdata_in} = '0;
    err_count = 0;
    tests_run = 0;
    repeat (6) @(negedge clock_in);
    nrst_in = 1'b1;
    chk("len_rst", 16'h1, length_out);
    t_xdp();
    t_xptr();
    t_code();
    t_jmp();
    t_len();
    t_iram();
    results();
  end
  // the tests need about 80 cycles; allow many times that
  initial begin
    #20000;
    err_count++;
    results();
  end
endmodule
